// ===== dv/eeprom_byte_access_ctrl_tb.sv
// Purpose: Self-checking bench for the nonvolatile byte store controller
// Assumes: Register port per the hand-over contract, slow tick from the bench
// Notes:   Expected results are queued by the driver and checked by monitors
module eeprom_byte_access_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ebac_pkg::*;
   localparam int TICKS = 3;
   // Clock and reset
   logic       i_clk;
   logic       i_rstn;
   // Register port
   logic [7:0] i_sfr_addr;
   logic       i_sfr_wr;
   logic       i_sfr_rd;
   logic [7:0] i_sfr_wdata;
   logic [7:0] o_sfr_rdata;
   // Slow tick, interrupt hookup and status
   logic       i_sub_tick;
   logic       i_global_irq_enable;
   logic       i_stack_full;
   logic       i_irq_ack;
   logic       o_irq_req;
   logic       o_busy;
   int         err_total;
   int         checks_done;
   logic [7:0] exp_q[$];
   logic       bit_q[$];
   logic       chk_rd, rd_q, bit_chk, bit_sel, tick_en;
   logic [1:0] tick_cnt;
   logic [7:0] port, a, d;
   logic [7:0] mem[256];
   logic [7:0] addrs[8];
   int         seed;

   ebac_ctrl #(.READ_LAT(2), .WR_TICKS(TICKS)) dut_u (
      .i_clk(i_clk), .i_rstn(i_rstn), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
      .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
      .i_sub_tick(i_sub_tick), .i_global_irq_enable(i_global_irq_enable),
      .i_stack_full(i_stack_full), .i_irq_ack(i_irq_ack), .o_irq_req(o_irq_req),
      .o_busy(o_busy));

   always #25 i_clk = ~i_clk;

   ////////////////////////////////////////////////////////////////////////////////
   // Slow timer tick, one pulse every four clocks while enabled
   always @(negedge i_clk) begin
      tick_cnt   <= tick_cnt + 2'd1;
      i_sub_tick <= tick_en && (tick_cnt == 2'd3);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Compare tasks and monitors
   task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cmp_bit(input string nm, input logic e, input logic g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %b seen %b", nm, e, g);
      end
   endtask

   always @(posedge i_clk) rd_q <= i_sfr_rd && chk_rd;

   always @(negedge i_clk) begin
      if (rd_q) cmp_byte("rdata", exp_q.pop_front(), o_sfr_rdata);
   end

   always @(posedge i_clk) begin
      if (bit_chk) cmp_bit(bit_sel ? "busy" : "irq_req", bit_q.pop_front(),
                           bit_sel ? o_busy : o_irq_req);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bus tasks
   task automatic sfr_wr(input logic [7:0] ad, input logic [7:0] dt);
      i_sfr_addr  = ad;
      i_sfr_wdata = dt;
      i_sfr_wr    = 1'b1;
      @(posedge i_clk) i_sfr_wr <= 1'b0;
      @(negedge i_clk);
   endtask

   task automatic sfr_rd(input logic [7:0] ad, input logic chk, input logic [7:0] e);
      i_sfr_addr = ad;
      i_sfr_rd   = 1'b1;
      chk_rd     = chk;
      if (chk) exp_q.push_back(e);
      @(posedge i_clk) i_sfr_rd <= 1'b0;
      @(negedge i_clk);
   endtask

   task automatic chk_bit(input logic sel, input logic e);
      bit_sel = sel;
      bit_q.push_back(e);
      bit_chk = 1'b1;
      @(negedge i_clk) bit_chk = 1'b0;
   endtask

   task automatic poll(input int bn);
      int n;
      for (n = 0; n < 100; n++) begin
         sfr_rd(port, 1'b0, 8'h00);
         if (o_sfr_rdata[bn] === 1'b0) break;
      end
      if (n == 100) begin
         err_total++;
         $display("mismatch poll bit %0d expected 0 seen 1", bn);
      end
   endtask

   task automatic setup_ptr();
      sfr_wr(ADR_PTR1_LOW, CTRL_OFFSET);
      sfr_wr(ADR_PTR1_HIGH, CTRL_SECTOR);
      sfr_wr(ADR_PTR2_LOW, CTRL_OFFSET);
      sfr_wr(ADR_PTR2_HIGH, CTRL_SECTOR);
   endtask

   task automatic write_byte(input logic [7:0] ad, input logic [7:0] dt);
      tick_en = 1'b1;
      sfr_wr(ADR_NVM_ADDRESS, ad);
      sfr_wr(ADR_NVM_DATA, dt);
      i_global_irq_enable = 1'b0;
      sfr_wr(port, 8'h08);
      sfr_wr(port, 8'h0C);
      i_global_irq_enable = 1'b1;
      poll(BIT_PROG_GO);
      sfr_wr(port, 8'h00);
      mem[ad] = dt;
   endtask

   task automatic read_byte(input logic [7:0] ad);
      sfr_wr(ADR_NVM_ADDRESS, ad);
      // Spoil the data register so only the fetch can restore it
      sfr_wr(ADR_NVM_DATA, ~mem[ad]);
      sfr_wr(port, 8'h02);
      sfr_wr(port, 8'h03);
      poll(BIT_READ_START);
      sfr_rd(ADR_NVM_DATA, 1'b1, mem[ad]);
      sfr_rd(ADR_NVM_DATA, 1'b1, mem[ad]);
      sfr_wr(port, 8'h00);
   endtask

   task automatic do_reset();
      i_rstn = 1'b0;
      repeat (2) @(negedge i_clk);
      i_rstn = 1'b1;
   endtask

   task automatic close_out();
      $display("checks_done %0d err_total %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {i_clk, i_sfr_wr, i_sfr_rd, i_sub_tick, i_irq_ack, i_stack_full} = '0;
      {chk_rd, bit_chk, bit_sel, tick_en, i_global_irq_enable} = '0;
      {i_sfr_addr, i_sfr_wdata, tick_cnt} = '0;
      {err_total, checks_done} = '0;
      seed = 32'h9fcf;
      port = ADR_IND_PORT1;
      i_rstn = 1'b0;
      repeat (2) @(negedge i_clk);
      i_rstn = 1'b1;
      addrs = '{ADR_NVM_ADDRESS, ADR_NVM_DATA, ADR_IRQ_CTRL, ADR_IND_PORT1, 8'hFF,
                ADR_PTR1_HIGH, ADR_PTR2_HIGH, ADR_IND_PORT2};
      sfr_wr(8'hFF, 8'h5A);
      foreach (addrs[i]) sfr_rd(addrs[i], 1'b1, 8'h00);
      setup_ptr();
      sfr_rd(port, 1'b1, 8'h00);
      sfr_wr(port, 8'hF2);
      sfr_rd(port, 1'b1, 8'h02);
      sfr_wr(port, 8'h00);
      sfr_wr(port, 8'h01);
      sfr_rd(port, 1'b1, 8'h00);
      sfr_wr(port, 8'h04);
      sfr_rd(port, 1'b1, 8'h00);
      // Write held off while the slow timer stands still
      sfr_wr(ADR_NVM_ADDRESS, 8'h00);
      sfr_wr(ADR_NVM_DATA, 8'hA5);
      sfr_wr(port, 8'h08);
      sfr_wr(port, 8'h0C);
      repeat (20) @(negedge i_clk);
      chk_bit(1'b1, 1'b1);
      sfr_rd(port, 1'b1, 8'h0C);
      sfr_rd(ADR_IRQ_CTRL, 1'b1, 8'h00);
      tick_en = 1'b1;
      poll(BIT_PROG_GO);
      mem[0] = 8'hA5;
      sfr_wr(port, 8'h00);
      chk_bit(1'b1, 1'b0);
      sfr_rd(ADR_IRQ_CTRL, 1'b1, 8'h0C);
      chk_bit(1'b0, 1'b0);
      sfr_wr(ADR_IRQ_CTRL, 8'h0F);
      chk_bit(1'b0, 1'b0);
      i_global_irq_enable = 1'b1;
      chk_bit(1'b0, 1'b1);
      i_stack_full = 1'b1;
      chk_bit(1'b0, 1'b0);
      i_stack_full = 1'b0;
      sfr_wr(ADR_IRQ_CTRL, 8'h0D);
      chk_bit(1'b0, 1'b0);
      sfr_wr(ADR_IRQ_CTRL, 8'h0F);
      i_irq_ack = 1'b1;
      @(negedge i_clk) i_irq_ack = 1'b0;
      chk_bit(1'b0, 1'b0);
      sfr_rd(ADR_IRQ_CTRL, 1'b1, 8'h07);
      sfr_wr(ADR_IRQ_CTRL, 8'h03);
      sfr_rd(ADR_IRQ_CTRL, 1'b1, 8'h03);
      sfr_wr(ADR_IRQ_CTRL, 8'h00);
      read_byte(8'h00);
      for (int i = 0; i < 6; i++) begin
         port = i[0] ? ADR_IND_PORT2 : ADR_IND_PORT1;
         a = (i == 0) ? 8'hFF : (i == 1) ? 8'h01 : 8'($random(seed));
         d = 8'($random(seed));
         write_byte(a, d);
         read_byte(a);
      end
      read_byte(8'h00);
      sfr_wr(port, 8'h0A);
      do_reset();
      sfr_rd(port, 1'b1, 8'h00);
      sfr_rd(ADR_NVM_DATA, 1'b1, 8'h00);
      setup_ptr();
      sfr_rd(port, 1'b1, 8'h00);
      repeat (2) @(negedge i_clk);
      close_out();
   end

   initial begin
      repeat (20000) @(posedge i_clk);
      err_total++;
      close_out();
   end
endmodule

// ===== hdl/ebac_ctrl.sv
// Purpose: Byte read/write controller for a 256x8 nonvolatile data store
// Assumes: Core reaches registers through its special function register port
// Notes:   Write timing runs off the slow subsidiary clock tick
//
// Functional notes
// - Store holds 256 bytes, reached only by single-byte read and write cycles.
// - Address and data registers sit in sector 0, directly accessible.
// - Control register at 40H of sector 1, reached through indirect ports.
// - Control bits 7 to 4 always read as zero.
// - Program permit zero blocks every write cycle.
// - Program go starts a write only with permit set; hardware clears it.
// - Read permit zero blocks every read cycle.
// - Read start begins a read only with permit set; cleared at end.
// - Data register keeps fetched byte until the next read or write.
// - Write duration comes from the slow asynchronous timer, not system clocks.
// - Power-on clears the program permit.
// - Power-on clears both pointer high bytes, selecting sector 0.
// - Write end sets done flag and multi-function flag.
// - Interrupt request needs global, done, multi-function enables and room on stack.
// - Servicing clears only the multi-function flag; done flag stays.
module ebac_ctrl
   import ebac_pkg::*;
#(
   parameter int READ_LAT  = READ_CYCLES,
   parameter int WR_TICKS  = WRITE_TICKS
)(
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rstn,
   // Special function register port
   input  wire logic [7:0]        i_sfr_addr,
   input  wire logic              i_sfr_wr,
   input  wire logic              i_sfr_rd,
   input  wire logic [7:0]        i_sfr_wdata,
   output logic      [7:0]        o_sfr_rdata,
   // Slow subsidiary timer
   input  wire logic              i_sub_tick,
   // Interrupt hookup
   input  wire logic              i_global_irq_enable,
   input  wire logic              i_stack_full,
   input  wire logic              i_irq_ack,
   output logic                   o_irq_req,
   // Status
   output logic                   o_busy
);

   localparam int RC_W = $clog2(READ_LAT + 1);
   localparam int TC_W = $clog2(WR_TICKS + 1);

   ////////////////////////////////////////////////////////////////////////
   // State

   logic [7:0]      mem [DEPTH];
   logic [7:0]      nvm_address;
   logic [7:0]      nvm_data;
   logic [7:0]      pointer1_low;
   logic [7:0]      pointer1_high;
   logic [7:0]      pointer2_low;
   logic [7:0]      pointer2_high;
   logic            program_permit;
   logic            prog_go;
   logic            read_permit;
   logic            read_start;
   logic            nvm_done_irq_enable;
   logic            mf_irq_enable;
   logic            nvm_done_irq_flag;
   logic            mf_irq_flag;
   ebac_state_e     state;
   logic [RC_W-1:0] rd_cnt;
   logic [TC_W-1:0] tick_cnt;

   ////////////////////////////////////////////////////////////////////////
   // Decode

   // Pointer pair lands on the control register
   function automatic logic hits_ctrl(input logic [7:0] high, input logic [7:0] low);
      return (high == CTRL_SECTOR) && (low == CTRL_OFFSET);
   endfunction

   logic ctrl_sel;
   logic ctrl_wr;
   logic ctrl_rd;
   logic read_launch;
   logic write_launch;
   logic read_done;
   logic write_done;
   logic done_sw_clr;
   logic [7:0] ctrl_byte;
   logic [7:0] irq_byte;
   logic [7:0] rd_byte;

   always_comb begin
      ctrl_sel = ((i_sfr_addr == ADR_IND_PORT1) && hits_ctrl(pointer1_high, pointer1_low)) ||
                 ((i_sfr_addr == ADR_IND_PORT2) && hits_ctrl(pointer2_high, pointer2_low));
   end

   assign ctrl_wr = i_sfr_wr && ctrl_sel;
   assign ctrl_rd = i_sfr_rd && ctrl_sel;

   // Launch only on permit already held, and only from idle
   assign write_launch = ctrl_wr && i_sfr_wdata[BIT_PROG_GO] && program_permit
                         && (state == ST_IDLE);
   assign read_launch  = ctrl_wr && i_sfr_wdata[BIT_READ_START] && read_permit
                         && (state == ST_IDLE) && !i_sfr_wdata[BIT_PROG_GO];
   assign read_done    = (state == ST_READ) && (rd_cnt == RC_W'(READ_LAT - 1));
   assign write_done   = (state == ST_WRITE) && i_sub_tick
                         && (tick_cnt == TC_W'(WR_TICKS - 1));
   assign done_sw_clr  = i_sfr_wr && (i_sfr_addr == ADR_IRQ_CTRL)
                         && !i_sfr_wdata[BIT_DONE_FLAG];
   assign rd_byte      = mem[nvm_address];

   // Upper nibble unimplemented
   assign ctrl_byte = {4'h0, program_permit, prog_go, read_permit, read_start};
   assign irq_byte  = {4'h0, mf_irq_flag, nvm_done_irq_flag, mf_irq_enable,
                       nvm_done_irq_enable};

   ////////////////////////////////////////////////////////////////////////
   // Sequencer

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state <= ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (write_launch) begin
                  state <= ST_WRITE;
               end else if (read_launch) begin
                  state <= ST_READ;
               end
            end
            ST_READ: begin
               if (read_done) begin
                  state <= ST_IDLE;
               end
            end
            ST_WRITE: begin
               if (write_done) begin
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rd_cnt <= '0;
      end else if (state == ST_READ && !read_done) begin
         rd_cnt <= rd_cnt + RC_W'(1);
      end else begin
         rd_cnt <= '0;
      end
   end

   // Write time counted in slow timer ticks only
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         tick_cnt <= '0;
      end else if (state != ST_WRITE || write_done) begin
         tick_cnt <= '0;
      end else if (i_sub_tick) begin
         tick_cnt <= tick_cnt + TC_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control register

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         program_permit <= 1'b0;
         read_permit    <= 1'b0;
      end else if (ctrl_wr) begin
         program_permit <= i_sfr_wdata[BIT_PROG_PERMIT];
         read_permit    <= i_sfr_wdata[BIT_READ_PERMIT];
      end
   end

   // Start bits: software may only set, hardware clears at end
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         prog_go <= 1'b0;
      end else if (write_launch) begin
         prog_go <= 1'b1;
      end else if (write_done) begin
         prog_go <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         read_start <= 1'b0;
      end else if (read_launch) begin
         read_start <= 1'b1;
      end else if (read_done) begin
         read_start <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sector 0 registers and pointers

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         nvm_address <= RESET_BYTE;
      end else if (i_sfr_wr && i_sfr_addr == ADR_NVM_ADDRESS) begin
         nvm_address <= i_sfr_wdata;
      end
   end

   // Fetched byte wins over a software write in the same cycle
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         nvm_data <= RESET_BYTE;
      end else if (read_done) begin
         nvm_data <= rd_byte;
      end else if (i_sfr_wr && i_sfr_addr == ADR_NVM_DATA) begin
         nvm_data <= i_sfr_wdata;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pointer1_low  <= RESET_BYTE;
         pointer1_high <= RESET_BYTE;
         pointer2_low  <= RESET_BYTE;
         pointer2_high <= RESET_BYTE;
      end else if (i_sfr_wr) begin
         if (i_sfr_addr == ADR_PTR1_LOW)  pointer1_low  <= i_sfr_wdata;
         if (i_sfr_addr == ADR_PTR1_HIGH) pointer1_high <= i_sfr_wdata;
         if (i_sfr_addr == ADR_PTR2_LOW)  pointer2_low  <= i_sfr_wdata;
         if (i_sfr_addr == ADR_PTR2_HIGH) pointer2_high <= i_sfr_wdata;
      end
   end

   // Store written when the timed cycle ends
   always_ff @(posedge i_clk) begin
      if (write_done) begin
         mem[nvm_address] <= nvm_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt flags

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         nvm_done_irq_enable <= 1'b0;
         mf_irq_enable       <= 1'b0;
      end else if (i_sfr_wr && i_sfr_addr == ADR_IRQ_CTRL) begin
         nvm_done_irq_enable <= i_sfr_wdata[BIT_DONE_EN];
         mf_irq_enable       <= i_sfr_wdata[BIT_MF_EN];
      end
   end

   // Set wins over software clear; ack leaves the done flag alone
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         nvm_done_irq_flag <= 1'b0;
      end else if (write_done) begin
         nvm_done_irq_flag <= 1'b1;
      end else if (done_sw_clr) begin
         nvm_done_irq_flag <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         mf_irq_flag <= 1'b0;
      end else if (write_done) begin
         mf_irq_flag <= 1'b1;
      end else if (i_irq_ack ||
                   (i_sfr_wr && i_sfr_addr == ADR_IRQ_CTRL && !i_sfr_wdata[BIT_MF_FLAG])) begin
         mf_irq_flag <= 1'b0;
      end
   end

   assign o_irq_req = mf_irq_flag && i_global_irq_enable && nvm_done_irq_enable
                      && mf_irq_enable && !i_stack_full;
   assign o_busy    = (state != ST_IDLE);

   ////////////////////////////////////////////////////////////////////////
   // Read-back

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_sfr_rdata <= ZERO_BYTE;
      end else if (ctrl_rd) begin
         o_sfr_rdata <= ctrl_byte;
      end else if (i_sfr_rd) begin
         unique case (i_sfr_addr)
            ADR_NVM_ADDRESS: o_sfr_rdata <= nvm_address;
            ADR_NVM_DATA:    o_sfr_rdata <= nvm_data;
            ADR_IRQ_CTRL:    o_sfr_rdata <= irq_byte;
            ADR_PTR1_LOW:    o_sfr_rdata <= pointer1_low;
            ADR_PTR1_HIGH:   o_sfr_rdata <= pointer1_high;
            ADR_PTR2_LOW:    o_sfr_rdata <= pointer2_low;
            ADR_PTR2_HIGH:   o_sfr_rdata <= pointer2_high;
            default:         o_sfr_rdata <= ZERO_BYTE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   sequence seq_read_go;
      $rose(read_start);
   endsequence

   sequence seq_read_end;
      ##[1:8] $fell(read_start);
   endsequence

   chk_ctrl_upper_zero: assert property (ctrl_rd |=> o_sfr_rdata[7:4] == 4'h0)
      else $error("control upper nibble not zero");

   chk_write_gate: assert property ($rose(prog_go) |-> $past(program_permit))
      else $error("write began without program permit");

   chk_go_clear: assert property (write_done |=> !prog_go && state == ST_IDLE)
      else $error("program go not cleared at write end");

   chk_read_gate: assert property (seq_read_go |-> $past(read_permit))
      else $error("read began without read permit");

   chk_read_ends: assert property (seq_read_go |-> seq_read_end)
      else $error("read start never cleared");

   chk_data_hold: assert property (state == ST_IDLE && !(i_sfr_wr && i_sfr_addr == ADR_NVM_DATA)
                                   |=> $stable(nvm_data))
      else $error("data register changed while idle");

   chk_write_on_tick: assert property (write_done |-> i_sub_tick && prog_go)
      else $error("write ended without slow timer tick");

   chk_done_flags: assert property (write_done |=> nvm_done_irq_flag && mf_irq_flag)
      else $error("write end did not raise both flags");

   chk_irq_gate: assert property (o_irq_req |-> i_global_irq_enable && !i_stack_full
                                  && nvm_done_irq_enable && mf_irq_enable)
      else $error("interrupt raised while gated");

   chk_ack_clear: assert property (i_irq_ack && !write_done && nvm_done_irq_flag && !done_sw_clr
                                   |=> !mf_irq_flag && nvm_done_irq_flag)
      else $error("service cleared wrong flag");

   chk_data_load: assert property ($fell(read_start) |-> nvm_data == $past(rd_byte))
      else $error("fetched byte missing at read end");

endmodule

// ===== hdl/ebac_pkg.sv
// Purpose: Constants for the byte-wide nonvolatile store controller
// Assumes: 8-bit special function register port of the core
// Notes:   Sector 0 register addresses are local choices
package ebac_pkg;
   localparam int          DATA_W          = 8;
   localparam int          DEPTH           = 256;
   // Sector 0 register addresses
   localparam logic [7:0]  ADR_NVM_ADDRESS = 8'h1A;
   localparam logic [7:0]  ADR_NVM_DATA    = 8'h1B;
   localparam logic [7:0]  ADR_IRQ_CTRL    = 8'h1C;
   localparam logic [7:0]  ADR_PTR1_LOW    = 8'h03;
   localparam logic [7:0]  ADR_PTR1_HIGH   = 8'h04;
   localparam logic [7:0]  ADR_PTR2_LOW    = 8'h05;
   localparam logic [7:0]  ADR_PTR2_HIGH   = 8'h06;
   localparam logic [7:0]  ADR_IND_PORT1   = 8'h02;
   localparam logic [7:0]  ADR_IND_PORT2   = 8'h07;
   // Control register location in sector 1
   localparam logic [7:0]  CTRL_SECTOR     = 8'h01;
   localparam logic [7:0]  CTRL_OFFSET     = 8'h40;
   // Control register fields
   localparam int          BIT_PROG_PERMIT = 3;
   localparam int          BIT_PROG_GO     = 2;
   localparam int          BIT_READ_PERMIT = 1;
   localparam int          BIT_READ_START  = 0;
   // Interrupt control register fields
   localparam int          BIT_DONE_EN     = 0;
   localparam int          BIT_MF_EN       = 1;
   localparam int          BIT_DONE_FLAG   = 2;
   localparam int          BIT_MF_FLAG     = 3;
   localparam logic [7:0]  RESET_BYTE      = 8'h00;
   localparam logic [7:0]  ZERO_BYTE       = 8'h00;
   // Timing defaults
   localparam int          READ_CYCLES     = 2;
   localparam int          WRITE_TICKS     = 4;
   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} ebac_state_e;
endpackage
